// ===== rtl/ssiro_top.sv
// Behaviour
// - sync mode starts transfer on sync pulse
// - start jitter bounded by few link cycles
// - too-fast cycle raises sync fault flag
// - four-byte position plus status per channel
// - two-byte status keeps low byte meanings
// - restore key returns all settings default
// - frame error suppress flag, reset zero
// - power-fail option maps last bit status2
// - minimum gap time in us, enabled flag
// - coding 0 binary, 1 Gray, default Gray
// - baud codes 1..5, default code 3
// - type 0 25 bits, type 1 13
// - type 2 uses frame size setting
// - frame size 0..32, reset 25
// - position length 0..32, reset 24
// - shift time fixed while running
// - no start before gap time elapsed
// - position formed from length setting bits
// - high trailing level flags frame error
`timescale 1ns/10ps
`default_nettype none
module ssiro_top import ssiro_pkg::*; #(
  parameter int CYC_US = CYC_PER_US,
  parameter logic [31:0] SHIFT_TIME_US = 32'h0000_0000
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // object access
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic obj_wr,
  input wire logic obj_rd,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_ack,
  output logic obj_err,
  // triggers and mode
  input wire logic frame_arrival,
  input wire logic sync_pulse,
  input wire logic distributed_time_mode,
  input wire logic include_shift_times,
  input wire logic status_two_bytes,
  // encoder link
  output logic ssi_clk_out,
  input wire logic ssi_data_in,
  // process data
  output logic [31:0] pos_value,
  output logic [15:0] status_word,
  output logic data_valid,
  output logic sync_fault_flag,
  output logic [31:0] input_shift_time,
  output logic test_mode_out
);
  logic rst_s1_reg, rst_n_reg, lrst_s1_reg, lrst_n_reg;
  logic [31:0] key_reg;
  logic supp_reg, pf_reg, inh_reg, test_reg;
  logic [15:0] coding_reg, baud_reg, ftype_reg, fsize_reg, plen_reg, gap_reg;
  logic [31:0] rd_val;
  logic hit, w_ok, restore;
  logic [5:0] nbits;
  logic [7:0] half;
  logic cfg_bad;
  logic sy1_reg, sy2_reg, sy3_reg, sync_rise, trig;
  logic busy_reg, pend_reg, gap_active, launch, overrun;
  logic [15:0] gap_us_reg, pre_reg;
  logic start_tgl_reg, bad_l_reg;
  logic [5:0] cfg_nbits_reg;
  logic [7:0] cfg_half_reg;
  logic st1_reg, st2_reg, st3_reg, start_ev;
  logic ds1_reg, d_s_reg;
  ssiro_link_t l_state;
  logic [7:0] hc_reg, half_l_reg;
  logic [5:0] bc_reg;
  logic [31:0] sh_reg;
  logic derr_reg, ferr_reg, done_tgl_reg;
  logic dn1_reg, dn2_reg, dn3_reg, done_seen;
  logic [31:0] data_w, mask, masked, bin;

  // reset release, one synchroniser per domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1_reg <= 1'b0;
      lrst_n_reg <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n_reg <= lrst_s1_reg;
    end
  end

  // object decode: out-of-range writes are refused and keep the old value
  always_comb begin
    rd_val = '0;
    hit = 1'b0;
    w_ok = 1'b0;
    case (obj_index)
      IDX_RESTORE: begin
        if (obj_sub == SUB_LEN) begin
          hit = 1'b1;
          rd_val = {24'h00_0000, RESTORE_LEN};
        end else if (obj_sub == SUB_1) begin
          hit = 1'b1;
          w_ok = 1'b1;
          rd_val = key_reg;
        end
      end
      IDX_OPTIONS: begin
        hit = (obj_sub <= SUB_4);
        w_ok = hit && (obj_sub != SUB_LEN) && (obj_wdata[31:1] == '0);
        case (obj_sub)
          SUB_LEN: rd_val = {24'h00_0000, OPTIONS_LEN};
          SUB_1: rd_val = {31'h0000_0000, supp_reg};
          SUB_2: rd_val = {31'h0000_0000, pf_reg};
          SUB_3: rd_val = {31'h0000_0000, inh_reg};
          SUB_4: rd_val = {31'h0000_0000, test_reg};
          default: rd_val = '0;
        endcase
      end
      IDX_CODING, IDX_BAUD, IDX_FTYPE, IDX_FSIZE, IDX_PLEN, IDX_GAP: begin
        hit = (obj_sub == SUB_LEN);
        case (obj_index)
          IDX_CODING: rd_val = {16'h0000, coding_reg};
          IDX_BAUD: rd_val = {16'h0000, baud_reg};
          IDX_FTYPE: rd_val = {16'h0000, ftype_reg};
          IDX_FSIZE: rd_val = {16'h0000, fsize_reg};
          IDX_PLEN: rd_val = {16'h0000, plen_reg};
          default: rd_val = {16'h0000, gap_reg};
        endcase
        if (!hit || obj_wdata[31:16] != '0) begin
          w_ok = 1'b0;
        end else begin
          case (obj_index)
            IDX_CODING: w_ok = (obj_wdata[15:0] <= CODING_GRAY);
            IDX_BAUD: w_ok = (obj_wdata[15:0] >= BAUD_1250) && (obj_wdata[15:0] <= BAUD_125);
            IDX_FTYPE: w_ok = (obj_wdata[15:0] <= FTYPE_VAR);
            IDX_FSIZE, IDX_PLEN: w_ok = (obj_wdata[15:0] <= MAX_FRAME_BITS);
            default: w_ok = 1'b1;
          endcase
        end
      end
      default: ;
    endcase
  end
  assign restore = obj_wr && w_ok && (obj_index == IDX_RESTORE) && (obj_wdata == RESTORE_KEY);

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= '0;
    end else begin
      obj_ack <= obj_wr || obj_rd;
      obj_err <= (obj_wr || obj_rd) && (!hit || (obj_wr && !w_ok));
      if (obj_rd) begin
        obj_rdata <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      key_reg <= '0;
      {supp_reg, pf_reg, inh_reg, test_reg} <= '0;
      coding_reg <= DEF_CODING;
      baud_reg <= DEF_BAUD;
      ftype_reg <= DEF_FTYPE;
      fsize_reg <= DEF_FSIZE;
      plen_reg <= DEF_PLEN;
      gap_reg <= DEF_GAP;
    end else if (restore) begin
      key_reg <= obj_wdata;
      {supp_reg, pf_reg, inh_reg, test_reg} <= '0;
      coding_reg <= DEF_CODING;
      baud_reg <= DEF_BAUD;
      ftype_reg <= DEF_FTYPE;
      fsize_reg <= DEF_FSIZE;
      plen_reg <= DEF_PLEN;
      gap_reg <= DEF_GAP;
    end else if (obj_wr && w_ok) begin
      case (obj_index)
        IDX_RESTORE: key_reg <= obj_wdata;
        IDX_OPTIONS: begin
          case (obj_sub)
            SUB_1: supp_reg <= obj_wdata[0];
            SUB_2: pf_reg <= obj_wdata[0];
            SUB_3: inh_reg <= obj_wdata[0];
            default: test_reg <= obj_wdata[0];
          endcase
        end
        IDX_CODING: coding_reg <= obj_wdata[15:0];
        IDX_BAUD: baud_reg <= obj_wdata[15:0];
        IDX_FTYPE: ftype_reg <= obj_wdata[15:0];
        IDX_FSIZE: fsize_reg <= obj_wdata[15:0];
        IDX_PLEN: plen_reg <= obj_wdata[15:0];
        default: gap_reg <= obj_wdata[15:0];
      endcase
    end
  end

  // frame length and bit half period from the settings
  always_comb begin
    case (ftype_reg)
      FTYPE_SINGLE: nbits = SINGLE_BITS;
      FTYPE_VAR: nbits = fsize_reg[5:0];
      default: nbits = MULTI_BITS;
    endcase
    case (baud_reg)
      BAUD_1250: half = HC_1250;
      BAUD_1000: half = HC_1000;
      BAUD_250: half = HC_250;
      BAUD_125: half = HC_125;
      default: half = HC_500;
    endcase
  end
  assign cfg_bad = (nbits == '0);

  // trigger selection; the sync pin is resampled, so jitter is about one ref cycle
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {sy1_reg, sy2_reg, sy3_reg} <= '0;
    end else begin
      {sy1_reg, sy2_reg, sy3_reg} <= {sync_pulse, sy1_reg, sy2_reg};
    end
  end
  assign sync_rise = sy2_reg && !sy3_reg;
  assign trig = distributed_time_mode ? sync_rise : frame_arrival;
  assign gap_active = inh_reg && (gap_us_reg != '0);
  assign launch = (trig || pend_reg) && !busy_reg && !gap_active;
  assign overrun = trig && (busy_reg || pend_reg);

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      busy_reg <= 1'b0;
      pend_reg <= 1'b0;
      start_tgl_reg <= 1'b0;
      cfg_nbits_reg <= MULTI_BITS;
      cfg_half_reg <= HC_500;
      bad_l_reg <= 1'b0;
    end else begin
      if (launch) begin
        busy_reg <= 1'b1;
        start_tgl_reg <= !start_tgl_reg;
        cfg_nbits_reg <= nbits;
        cfg_half_reg <= half;
        bad_l_reg <= cfg_bad;
      end else if (done_seen) begin
        busy_reg <= 1'b0;
      end
      if (launch) begin
        pend_reg <= 1'b0;
      end else if (trig) begin
        pend_reg <= 1'b1;
      end
    end
  end

  // set wins over the clear of a clean launch
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sync_fault_flag <= 1'b0;
    end else if (overrun) begin
      sync_fault_flag <= 1'b1;
    end else if (launch) begin
      sync_fault_flag <= 1'b0;
    end
  end

  // gap time counted from the end of the previous frame
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gap_us_reg <= '0;
      pre_reg <= '0;
    end else if (done_seen) begin
      gap_us_reg <= gap_reg;
      pre_reg <= 16'(CYC_US - 1);
    end else if (gap_us_reg != '0) begin
      if (pre_reg == '0) begin
        pre_reg <= 16'(CYC_US - 1);
        gap_us_reg <= gap_us_reg - 16'h0001;
      end else begin
        pre_reg <= pre_reg - 16'h0001;
      end
    end
  end

  // link domain; cfg_*_reg and sh_reg are held stable across each toggle handshake
  always_ff @(posedge link_clk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      {st1_reg, st2_reg, st3_reg} <= '0;
      {ds1_reg, d_s_reg} <= '0;
    end else begin
      {st1_reg, st2_reg, st3_reg} <= {start_tgl_reg, st1_reg, st2_reg};
      {ds1_reg, d_s_reg} <= {ssi_data_in, ds1_reg};
    end
  end
  assign start_ev = st2_reg ^ st3_reg;

  always_ff @(posedge link_clk or negedge lrst_n_reg) begin
    if (!lrst_n_reg) begin
      l_state <= L_IDLE;
      ssi_clk_out <= 1'b1;
      hc_reg <= '0;
      half_l_reg <= '0;
      bc_reg <= '0;
      sh_reg <= '0;
      derr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
    end else begin
      unique case (l_state)
        L_IDLE: begin
          if (start_ev) begin
            half_l_reg <= cfg_half_reg;
            hc_reg <= cfg_half_reg - 8'h01;
            bc_reg <= cfg_nbits_reg;
            sh_reg <= '0;
            derr_reg <= !d_s_reg;
            ssi_clk_out <= 1'b0;
            l_state <= L_LO;
          end
        end
        L_LO: begin
          if (hc_reg == '0) begin
            hc_reg <= half_l_reg - 8'h01;
            ssi_clk_out <= 1'b1;
            l_state <= L_HI;
          end else begin
            hc_reg <= hc_reg - 8'h01;
          end
        end
        L_HI: begin
          if (hc_reg != '0) begin
            hc_reg <= hc_reg - 8'h01;
          end else begin
            sh_reg <= {sh_reg[30:0], d_s_reg};
            bc_reg <= bc_reg - 6'h01;
            hc_reg <= half_l_reg - 8'h01;
            if (bc_reg <= 6'h01) begin
              l_state <= L_TAIL;
            end else begin
              ssi_clk_out <= 1'b0;
              l_state <= L_LO;
            end
          end
        end
        L_TAIL: begin
          if (hc_reg != '0) begin
            hc_reg <= hc_reg - 8'h01;
          end else begin
            ferr_reg <= d_s_reg;
            done_tgl_reg <= !done_tgl_reg;
            l_state <= L_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      {dn1_reg, dn2_reg, dn3_reg} <= '0;
    end else begin
      {dn1_reg, dn2_reg, dn3_reg} <= {done_tgl_reg, dn1_reg, dn2_reg};
    end
  end
  assign done_seen = dn2_reg ^ dn3_reg;

  // decode of the received frame
  assign data_w = pf_reg ? (sh_reg >> 1) : sh_reg;
  assign mask = (plen_reg >= MAX_FRAME_BITS) ? '1 : ((32'h0000_0001 << plen_reg[4:0]) - 32'h0000_0001);
  assign masked = data_w & mask;
  for (genvar gi = 0; gi < 32; gi++) begin : g_gray
    assign bin[gi] = ^(masked >> gi);
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pos_value <= '0;
      status_word <= '0;
      data_valid <= 1'b0;
      input_shift_time <= '0;
      test_mode_out <= 1'b0;
    end else begin
      data_valid <= done_seen;
      input_shift_time <= include_shift_times ? SHIFT_TIME_US : '0;
      test_mode_out <= test_reg;
      if (done_seen) begin
        pos_value <= (coding_reg == CODING_GRAY) ? bin : masked;
        status_word[ST_DATA_ERR] <= derr_reg || bad_l_reg;
        status_word[ST_FRAME_ERR] <= ferr_reg && !supp_reg;
        status_word[ST_POWER_FAIL] <= pf_reg && sh_reg[0];
      end
      status_word[15:8] <= status_two_bytes ? {7'h00, sync_fault_flag} : '0;
    end
  end

  sequence key_write_s;
    obj_wr && obj_index == IDX_RESTORE && obj_sub == SUB_1 && obj_wdata == RESTORE_KEY;
  endsequence
  sequence take_s;
    done_seen;
  endsequence

  restore_defaults_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    key_write_s |=> coding_reg == DEF_CODING && baud_reg == DEF_BAUD && fsize_reg == DEF_FSIZE
      && plen_reg == DEF_PLEN && !supp_reg) else $error("defaults not restored");
  size_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    obj_wr && obj_index == IDX_FSIZE && obj_sub == SUB_LEN && obj_wdata[15:0] > MAX_FRAME_BITS
      |=> $stable(fsize_reg) && obj_err) else $error("oversize frame accepted");
  sync_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    distributed_time_mode && !sync_rise && !pend_reg |-> !launch) else $error("start without sync");
  fault_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    trig && busy_reg |=> sync_fault_flag) else $error("sync fault missed");
  gap_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    gap_active |-> !launch) else $error("start inside gap");
  status_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    !status_two_bytes |=> status_word[15:8] == '0) else $error("high status byte set");
  suppress_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    take_s ##0 supp_reg |=> !status_word[ST_FRAME_ERR]) else $error("frame error not suppressed");
  power_fail_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    take_s ##0 pf_reg |=> status_word[ST_POWER_FAIL] == $past(sh_reg[0])) else $error("power fail bit");
  binary_pos_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    take_s ##0 coding_reg == CODING_BIN |=> pos_value == $past(masked)) else $error("binary position");
  single_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n_reg)
    ftype_reg == FTYPE_SINGLE |-> nbits == SINGLE_BITS) else $error("single turn length");
  link_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n_reg)
    l_state == L_IDLE |-> ssi_clk_out) else $error("link clock low when idle");
endmodule
`default_nettype wire

// ===== rtl/ssiro_pkg.sv
`default_nettype none
package ssiro_pkg;
  // object indices and subindices
  localparam logic [15:0] IDX_RESTORE = 16'h1011;
  localparam logic [15:0] IDX_OPTIONS = 16'h4061;
  localparam logic [15:0] IDX_CODING = 16'h4066;
  localparam logic [15:0] IDX_BAUD = 16'h4067;
  localparam logic [15:0] IDX_FTYPE = 16'h4068;
  localparam logic [15:0] IDX_FSIZE = 16'h4069;
  localparam logic [15:0] IDX_PLEN = 16'h406a;
  localparam logic [15:0] IDX_GAP = 16'h406b;
  localparam logic [7:0] SUB_LEN = 8'h00;
  localparam logic [7:0] SUB_1 = 8'h01;
  localparam logic [7:0] SUB_2 = 8'h02;
  localparam logic [7:0] SUB_3 = 8'h03;
  localparam logic [7:0] SUB_4 = 8'h04;
  // lengths, key and reset values
  localparam logic [7:0] RESTORE_LEN = 8'h01;
  localparam logic [7:0] OPTIONS_LEN = 8'h04;
  localparam logic [31:0] RESTORE_KEY = 32'h6461_6f6c;
  localparam logic [15:0] DEF_CODING = 16'h0001;
  localparam logic [15:0] DEF_BAUD = 16'h0003;
  localparam logic [15:0] DEF_FTYPE = 16'h0000;
  localparam logic [15:0] DEF_FSIZE = 16'h0019;
  localparam logic [15:0] DEF_PLEN = 16'h0018;
  localparam logic [15:0] DEF_GAP = 16'h0000;
  // field encodings
  localparam logic [15:0] CODING_BIN = 16'h0000;
  localparam logic [15:0] CODING_GRAY = 16'h0001;
  localparam logic [15:0] FTYPE_MULTI = 16'h0000;
  localparam logic [15:0] FTYPE_SINGLE = 16'h0001;
  localparam logic [15:0] FTYPE_VAR = 16'h0002;
  localparam logic [5:0] MULTI_BITS = 6'h19;
  localparam logic [5:0] SINGLE_BITS = 6'h0d;
  localparam logic [15:0] MAX_FRAME_BITS = 16'h0020;
  localparam logic [15:0] BAUD_1250 = 16'h0001;
  localparam logic [15:0] BAUD_1000 = 16'h0002;
  localparam logic [15:0] BAUD_500 = 16'h0003;
  localparam logic [15:0] BAUD_250 = 16'h0004;
  localparam logic [15:0] BAUD_125 = 16'h0005;
  // status word bit positions
  localparam int ST_DATA_ERR = 0;
  localparam int ST_FRAME_ERR = 1;
  localparam int ST_POWER_FAIL = 2;
  localparam int ST_SYNC_FAULT = 8;
  // timing
  localparam int REF_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 30;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = (NS_PER_US + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int HALF_NS_1250 = 400;
  localparam int HALF_NS_1000 = 500;
  localparam int HALF_NS_500 = 1000;
  localparam int HALF_NS_250 = 2000;
  localparam int HALF_NS_125 = 4000;
  localparam logic [7:0] HC_1250 = 8'((HALF_NS_1250 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] HC_1000 = 8'((HALF_NS_1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] HC_500 = 8'((HALF_NS_500 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] HC_250 = 8'((HALF_NS_250 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] HC_125 = 8'((HALF_NS_125 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  typedef enum logic [1:0] {L_IDLE, L_LO, L_HI, L_TAIL} ssiro_link_t;
endpackage
`default_nettype wire

// ===== bench/ssiro_enc.sv
`timescale 1ns/10ps
`default_nettype none
module ssiro_enc (
  // link
  input wire logic ssi_clk,
  output logic ssi_data,
  // frame set by the bench
  input wire logic [31:0] frame,
  input wire logic [15:0] nbits,
  input wire logic [15:0] half_ns,
  input wire logic tail_lvl
);
  int cnt = 0;
  initial ssi_data = 1'b1;
  // first falling edge of a frame loads the bit count
  always @(negedge ssi_clk) begin
    if (cnt == 0)
      cnt = nbits;
  end
  // msb first, next bit on each rising edge
  always @(posedge ssi_clk) begin
    if (cnt > 0) begin
      cnt = cnt - 1;
      ssi_data = frame[cnt];
      if (cnt == 0) begin
        #(half_ns * 3 / 2);
        ssi_data = tail_lvl;
        // back to idle soon, so a quick next start sees high
        #(half_ns / 2 + 100);
        ssi_data = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import ssiro_pkg::*; ;
  logic ref_clk = 0, link_clk = 0, rst_n = 0;
  logic [15:0] obj_index = 0, status_word, enc_n = 0, enc_half = 420;
  logic [7:0] obj_sub = 0;
  logic obj_wr = 0, obj_rd = 0, frame_arrival = 0, sync_pulse = 0, dtm = 0;
  logic inc_shift = 0, enc_tail = 0, obj_ack, obj_err, ssi_clk_out, ssi_data_in;
  logic data_valid, sync_fault_flag, test_mode_out;
  logic two_b = 1;
  logic [31:0] obj_wdata = 0, obj_rdata, pos_value, input_shift_time, enc_frame = 0;
  logic [31:0] seed = 32'h2362_36ee;
  int n_fail = 0, n_compared = 0, hc = 14;
  int hcs [5] = '{14, 17, 34, 67, 134};
  always #12.5 ref_clk = ~ref_clk;
  always #15 link_clk = ~link_clk;
  ssiro_top #(.CYC_US(2), .SHIFT_TIME_US(32'h0000_0007)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata),
    .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .frame_arrival(frame_arrival), .sync_pulse(sync_pulse),
    .distributed_time_mode(dtm), .include_shift_times(inc_shift),
    .status_two_bytes(two_b), .ssi_clk_out(ssi_clk_out), .ssi_data_in(ssi_data_in),
    .pos_value(pos_value), .status_word(status_word), .data_valid(data_valid),
    .sync_fault_flag(sync_fault_flag), .input_shift_time(input_shift_time),
    .test_mode_out(test_mode_out));
  ssiro_enc enc_u (.ssi_clk(ssi_clk_out), .ssi_data(ssi_data_in), .frame(enc_frame),
    .nbits(enc_n), .half_ns(enc_half), .tail_lvl(enc_tail));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // position model: drop the power-fail bit, keep pl bits, undo gray
  function automatic logic [31:0] exp_pos(logic [31:0] f, int pl, logic gr, logic pf);
    logic [31:0] v;
    v = pf ? f >> 1 : f;
    if (pl < 32)
      v = v & ((32'h1 << pl) - 1);
    if (gr)
      for (int i = pl - 2; i >= 0; i--) v[i] = v[i + 1] ^ v[i];
    return v;
  endfunction
  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] wd, input logic [31:0] exp, input logic ee);
    @(negedge ref_clk);
    obj_index = idx;
    obj_sub = sub;
    obj_wdata = wd;
    obj_wr = wr;
    obj_rd = !wr;
    @(negedge ref_clk);
    chk(obj_ack, 1);
    chk(obj_err, ee);
    if (!wr)
      chk(obj_rdata, exp);
    obj_wr = 0;
    obj_rd = 0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
      input logic ee);
    acc(1, i, s, d, 0, ee);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x,
      input logic ee);
    acc(0, i, s, 0, x, ee);
  endtask
  task automatic chk_defaults(input logic [31:0] key);
    rd(IDX_RESTORE, SUB_LEN, 32'h0000_0001, 0);
    rd(IDX_RESTORE, SUB_1, key, 0);
    rd(IDX_OPTIONS, SUB_LEN, 32'h0000_0004, 0);
    for (int s = 1; s <= 4; s++) rd(IDX_OPTIONS, 8'(s), 0, 0);
    rd(IDX_CODING, SUB_LEN, 32'h0000_0001, 0);
    rd(IDX_BAUD, SUB_LEN, 32'h0000_0003, 0);
    rd(IDX_FTYPE, SUB_LEN, 32'h0000_0000, 0);
    rd(IDX_FSIZE, SUB_LEN, 32'h0000_0019, 0);
    rd(IDX_PLEN, SUB_LEN, 32'h0000_0018, 0);
    rd(IDX_GAP, SUB_LEN, 32'h0000_0000, 0);
  endtask
  task automatic trig();
    @(negedge ref_clk);
    if (dtm)
      sync_pulse = 1;
    else
      frame_arrival = 1;
    repeat (dtm ? 3 : 1) @(negedge ref_clk);
    sync_pulse = 0;
    frame_arrival = 0;
  endtask
  task automatic wait_dv(input logic must, output int c);
    c = 0;
    while (data_valid !== 1'b1 && c < 20000) begin
      @(negedge ref_clk);
      c++;
    end
    if (c == 20000) begin
      n_fail++;
      $display("Error at %0t: no data valid", $time);
      stop_test();
    end
  endtask
  task automatic run(input int ft, fs, pl, input logic cd, pf, tl, sp);
    int n;
    int c;
    int e;
    logic [31:0] f;
    n = ft == 0 ? 25 : ft == 1 ? 13 : fs;
    wr(IDX_FTYPE, SUB_LEN, ft, 0);
    wr(IDX_FSIZE, SUB_LEN, fs, 0);
    wr(IDX_PLEN, SUB_LEN, pl, 0);
    wr(IDX_CODING, SUB_LEN, cd, 0);
    wr(IDX_OPTIONS, SUB_1, sp, 0);
    wr(IDX_OPTIONS, SUB_2, pf, 0);
    f = xs() & (n == 32 ? 32'hffff_ffff : (32'h1 << n) - 1);
    enc_frame = f;
    enc_n = 16'(n);
    enc_half = 16'(hc * 30);
    enc_tail = tl;
    trig();
    wait_dv(1, c);
    e = (2 * hc * n + hc) * 30 / 25;
    chk(pos_value, exp_pos(f, pl, cd, pf));
    chk(status_word, {13'h0, pf & f[0], tl & !sp, 1'b0});
    chk(c >= e && c <= e + 30, 1);
    $display("test frame type %0d size %0d done", ft, n);
  endtask
  initial begin
    int c;
    repeat (4) @(negedge ref_clk);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    chk(ssi_clk_out, 1);
    chk_defaults(0);
    wr(IDX_FSIZE, SUB_LEN, 33, 1);
    wr(IDX_PLEN, SUB_LEN, 33, 1);
    wr(IDX_BAUD, SUB_LEN, 0, 1);
    wr(IDX_BAUD, SUB_LEN, 6, 1);
    wr(IDX_CODING, SUB_LEN, 2, 1);
    wr(IDX_FTYPE, SUB_LEN, 3, 1);
    wr(IDX_OPTIONS, SUB_LEN, 1, 1);
    rd(16'h4070, SUB_LEN, 0, 1);
    chk_defaults(0);
    $display("test registers done");
    for (int b = 1; b <= 5; b++) begin
      hc = hcs[b - 1];
      wr(IDX_BAUD, SUB_LEN, b, 0);
      run(0, 0, 24, 1, 0, 0, 0);
    end
    // fastest rate for the rest keeps the run short
    hc = hcs[0];
    wr(IDX_BAUD, SUB_LEN, 1, 0);
    run(1, 0, 13, 0, 0, 0, 0);
    run(2, 32, 32, 0, 0, 0, 0);
    run(2, 30, 29, 1, 1, 0, 0);
    run(2, 16, 16, 0, 0, 1, 0);
    run(2, 16, 16, 0, 0, 1, 1);
    dtm = 1;
    @(negedge ref_clk);
    frame_arrival = 1;
    @(negedge ref_clk);
    frame_arrival = 0;
    c = 0;
    while (ssi_clk_out === 1'b1 && c < 300) begin
      @(negedge ref_clk);
      c++;
    end
    chk(c, 300);
    run(2, 16, 16, 0, 0, 0, 0);
    dtm = 0;
    trig();
    repeat (10) @(negedge ref_clk);
    trig();
    @(negedge ref_clk);
    chk(sync_fault_flag, 1);
    chk(status_word[15:8], 8'h01);
    two_b = 0;
    repeat (2) @(negedge ref_clk);
    chk(status_word[15:8], 8'h00);
    two_b = 1;
    wait_dv(1, c);
    @(negedge ref_clk);
    wait_dv(0, c);
    run(2, 16, 16, 0, 0, 0, 0);
    chk(sync_fault_flag, 0);
    wr(IDX_GAP, SUB_LEN, 200, 0);
    wr(IDX_OPTIONS, SUB_3, 1, 0);
    repeat (400) @(negedge ref_clk);
    run(2, 16, 16, 0, 0, 0, 0);
    trig();
    c = 0;
    while (ssi_clk_out === 1'b1 && c < 1000) begin
      @(negedge ref_clk);
      c++;
    end
    chk(c >= 390 && c <= 420, 1);
    wait_dv(1, c);
    inc_shift = 1;
    wr(IDX_OPTIONS, SUB_4, 1, 0);
    repeat (2) @(negedge ref_clk);
    chk(input_shift_time, 32'h0000_0007);
    chk(test_mode_out, 1);
    wr(IDX_RESTORE, SUB_1, 32'h6461_6f6d, 0);
    rd(IDX_FSIZE, SUB_LEN, 16, 0);
    wr(IDX_RESTORE, SUB_1, 32'h6461_6f6c, 0);
    chk_defaults(32'h6461_6f6c);
    $display("test modes and restore done");
    stop_test();
  end
endmodule
`default_nettype wire
